//--- src/rlfs_offset_sync.sv
// Network-side offset calculation, frame counter and synchronised config change
//
// What this block does
// RULE_01: Common channel state holds frame offset zero
// RULE_02: Single link: offsets equal default offset times 512
// RULE_03: Many links: add frame count and chip fraction
// RULE_04: Add or move link: offset from terminal report
// RULE_05: Other network entry reuses equations, zero frame count; code zeroes frame count only in time duplex
// RULE_06: Terminal seeds counter from cell frame, duplex frequency
// RULE_07: Terminal seeds counter from cell frame, time duplex
// RULE_08: Terminal from other network uses reference cell
// RULE_09: Connection frame number counts per frame, wraps 256
// RULE_10: Terminal reports frame count and chip fraction
// RULE_11: Time duplex terminal reports frame count only
// RULE_12: Base station rounds to nearest 256-chip boundary
// RULE_13: Prepare stations, confirm, then pick change frame
// RULE_14: Apply new configuration at signalled frame number
// RULE_15: Split chip count into frame quotient and remainder
`timescale 1ns/1ps
module rlfs_offset_sync (
   input  wire logic                      clk_sys,
   input  wire logic                      resetn,
   input  wire rlfs_pkg::rlfs_offset_req_t offsetReq,
   output rlfs_pkg::rlfs_offset_rsp_t      offsetRsp,
   input  wire logic                      frameTick,
   input  wire logic                      linkActive,
   input  wire logic [7:0]                cfnLoad,
   input  wire logic                      cfnLoadValid,
   output logic [7:0]                     connectionFrameNumber,
   input  wire rlfs_pkg::rlfs_cfg_req_t   cfgReq,
   output logic                           prepareCmd,
   input  wire logic                      prepareDone,
   output logic                           changeSignal,
   output logic [7:0]                     changeFrame,
   output logic                           applyConfig,
   output logic                           busy
);
   import rlfs_pkg::*;

   // -------------------------------------------------------------------------
   // Offset calculation
   // -------------------------------------------------------------------------
   logic [23:0] doffChips;
   logic [23:0] offChips;
   logic [23:0] totalChips;
   logic [7:0]  frameOff;
   logic [15:0] chipOff;
   logic [23:0] roundedChips;
   logic        roundCarry;
   logic [7:0]  roundFrame;
   logic [15:0] roundChip;

   // Chip counts of the terms that the offset equations add up
   always_comb begin
      doffChips = 24'(offsetReq.defaultDpchOffset) * 24'(DEFAULT_DPCH_OFFSET_UNIT);
      offChips  = 24'(offsetReq.frameCountOffset) * FRAME_CHIPS_W + 24'(offsetReq.chipFractionOffset);
   end

   // Combined chip count of the link case
   always_comb begin
      unique case (offsetReq.linkCase)
         CASE_COMMON:         totalChips = 24'h000000; // RULE_01
         CASE_FIRST_ONE:      totalChips = doffChips; // RULE_02
         CASE_FIRST_MANY:     totalChips = doffChips + offChips; // RULE_03
         CASE_ADD_OR_MOVE:    totalChips = offChips; // RULE_04
         CASE_FROM_OTHER_RAN: totalChips = doffChips + offChips; // RULE_05
         default:             totalChips = 24'h000000;
      endcase
   end

   // Whole frames and leftover chips; time duplex drops the chips and keeps only the add or move frame count, zero frames otherwise
   always_comb begin
      frameOff = 8'(totalChips / FRAME_CHIPS_W); // RULE_15
      chipOff  = 16'(totalChips % FRAME_CHIPS_W); // RULE_15
      if (offsetReq.timeDuplex) begin
         chipOff = ZERO_CHIPS;
         unique case (offsetReq.linkCase)
            CASE_ADD_OR_MOVE: frameOff = offsetReq.frameCountOffset; // RULE_04
            default:          frameOff = ZERO_FRAMES; // RULE_02 RULE_05
         endcase
      end
   end

   // Half-up rounding; a full frame of chips carries into the frame count
   always_comb begin
      roundedChips = (24'(chipOff) + ROUND_HALF_W) & ROUND_MASK_W; // RULE_12
      roundCarry   = roundedChips >= FRAME_CHIPS_W;
      if (roundCarry) begin
         roundFrame = frameOff + 8'h01; // RULE_12
         roundChip  = 16'(roundedChips - FRAME_CHIPS_W);
      end else begin
         roundFrame = frameOff;
         roundChip  = 16'(roundedChips);
      end
   end

   // -------------------------------------------------------------------------
   // Offset response
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         offsetRsp <= '0;
      end else begin
         offsetRsp.valid              <= offsetReq.valid;
         offsetRsp.linkFrameOffset    <= frameOff; // RULE_15
         offsetRsp.linkChipOffset     <= chipOff; // RULE_15
         offsetRsp.roundedFrameOffset <= roundFrame; // RULE_12
         offsetRsp.roundedChipOffset  <= roundChip; // RULE_12
      end
   end

   // -------------------------------------------------------------------------
   // Connection frame counter
   // -------------------------------------------------------------------------
   logic       cfnStep;
   logic [7:0] cfnNext_d;

   // A load wins over the frame step
   always_comb begin
      cfnStep   = cfnLoadValid || (linkActive && frameTick);
      cfnNext_d = connectionFrameNumber;
      if (cfnLoadValid) begin
         cfnNext_d = cfnLoad;
      end else if (linkActive && frameTick) begin
         cfnNext_d = connectionFrameNumber + 8'h01; // RULE_09
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         connectionFrameNumber <= 8'h00;
      end else begin
         connectionFrameNumber <= cfnNext_d; // RULE_09
      end
   end

   // -------------------------------------------------------------------------
   // Synchronised configuration change
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_PREPARE, ST_WAIT_FRAME} rlfs_chg_state_t;
   rlfs_chg_state_t chgState_q;
   logic [7:0]      pendFrame_q;
   logic            takeReq;
   logic            prepOk;
   logic            hitFrame;

   // A request while a change is pending is ignored
   always_comb begin
      takeReq  = 1'b0;
      prepOk   = 1'b0;
      hitFrame = 1'b0;
      unique case (chgState_q)
         ST_IDLE: begin
            takeReq = cfgReq.request;
         end
         ST_PREPARE: begin
            prepOk = prepareDone; // RULE_13
         end
         ST_WAIT_FRAME: begin
            // Same edge at which the counter takes the signalled value, by step or load
            hitFrame = cfnStep && (cfnNext_d == changeFrame); // RULE_14
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         chgState_q <= ST_IDLE;
      end else begin
         unique case (chgState_q)
            ST_IDLE: begin
               if (takeReq) begin
                  chgState_q <= ST_PREPARE; // RULE_13
               end
            end
            ST_PREPARE: begin
               if (prepOk) begin
                  chgState_q <= ST_WAIT_FRAME; // RULE_13
               end
            end
            ST_WAIT_FRAME: begin
               if (hitFrame) begin
                  chgState_q <= ST_IDLE; // RULE_14
               end
            end
         endcase
      end
   end

   // Frame chosen by the controller, held until the stations confirm
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         pendFrame_q <= 8'h00;
      end else if (takeReq) begin
         pendFrame_q <= cfgReq.changeFrame;
      end
   end

   // Stations are told to prepare before anything else is signalled
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         prepareCmd <= 1'b0;
      end else if (takeReq) begin
         prepareCmd <= 1'b1; // RULE_13
      end else if (prepOk) begin
         prepareCmd <= 1'b0; // RULE_13
      end
   end

   // Change frame goes out only after confirmation
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         changeSignal <= 1'b0;
         changeFrame  <= 8'h00;
      end else begin
         changeSignal <= prepOk; // RULE_13
         if (prepOk) begin
            changeFrame <= pendFrame_q; // RULE_13
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         applyConfig <= 1'b0;
      end else begin
         applyConfig <= hitFrame; // RULE_14
      end
   end

   // Busy from accepted request until the change is applied
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         busy <= 1'b0;
      end else if (takeReq) begin
         busy <= 1'b1;
      end else if (hitFrame) begin
         busy <= 1'b0; // RULE_14
      end
   end
endmodule

//--- shared/rlfs_pkg.sv
// Constants and carrier types for the radio link frame offset block
package rlfs_pkg;
   // -------------------------------------------------------------------------
   // Frame timing
   // -------------------------------------------------------------------------
   localparam int unsigned FRAME_CHIPS   = 38400;
   localparam int unsigned DEFAULT_DPCH_OFFSET_UNIT     = 512;
   localparam int unsigned ROUND_CHIPS   = 256;
   localparam int unsigned CFN_MOD       = 256;
   localparam logic [15:0] ZERO_CHIPS    = 16'h0000;
   localparam logic [7:0]  ZERO_FRAMES   = 8'h00;
   localparam logic [23:0] FRAME_CHIPS_W = 24'h009600;
   localparam logic [23:0] ROUND_HALF_W  = 24'h000080;
   localparam logic [23:0] ROUND_MASK_W  = 24'hffff00;

   // -------------------------------------------------------------------------
   // Modes and cases
   // -------------------------------------------------------------------------
   typedef enum logic [2:0] {
      CASE_COMMON,
      CASE_FIRST_ONE,
      CASE_FIRST_MANY,
      CASE_ADD_OR_MOVE,
      CASE_FROM_OTHER_RAN
   } rlfs_case_t;

   typedef struct packed {
      logic       valid;
      logic       timeDuplex;
      rlfs_case_t linkCase;
      logic [9:0] defaultDpchOffset;
      logic [7:0] frameCountOffset;
      logic [15:0] chipFractionOffset;
   } rlfs_offset_req_t;

   typedef struct packed {
      logic        valid;
      logic [7:0]  linkFrameOffset;
      logic [15:0] linkChipOffset;
      logic [7:0]  roundedFrameOffset;
      logic [15:0] roundedChipOffset;
   } rlfs_offset_rsp_t;

   typedef struct packed {
      logic       request;
      logic [7:0] changeFrame;
   } rlfs_cfg_req_t;
endpackage

//--- bench/rlfs_offset_sync_assertions.sv
// Checker for the radio link frame offset block
`timescale 1ns/1ps
module rlfs_offset_sync_chk (
   input wire logic                       clk_sys,
   input wire logic                       resetn,
   input wire rlfs_pkg::rlfs_offset_req_t offsetReq,
   input wire rlfs_pkg::rlfs_offset_rsp_t offsetRsp,
   input wire logic                       frameTick,
   input wire logic                       linkActive,
   input wire logic [7:0]                 cfnLoad,
   input wire logic                       cfnLoadValid,
   input wire logic [7:0]                 connectionFrameNumber,
   input wire rlfs_pkg::rlfs_cfg_req_t    cfgReq,
   input wire logic                       prepareCmd,
   input wire logic                       prepareDone,
   input wire logic                       changeSignal,
   input wire logic [7:0]                 changeFrame,
   input wire logic                       applyConfig,
   input wire logic                       busy
);
   import rlfs_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   sequence s_prep;
      prepareCmd && prepareDone;
   endsequence
   a_rsp_follows: assert property (offsetReq.valid |=> offsetRsp.valid)
      else $error("response missing");
   a_common_zero: assert property (offsetReq.valid && offsetReq.linkCase == CASE_COMMON |=>
      offsetRsp.linkFrameOffset == ZERO_FRAMES && offsetRsp.linkChipOffset == ZERO_CHIPS) else $error("common offset");
   a_chip_range: assert property (offsetRsp.valid |-> offsetRsp.linkChipOffset < FRAME_CHIPS_W)
      else $error("chip offset range");
   a_round_grid: assert property (offsetRsp.valid |-> offsetRsp.roundedChipOffset[7:0] == 8'h00)
      else $error("rounding grid");
   a_cfn_step: assert property (linkActive && frameTick && !cfnLoadValid |=>
      connectionFrameNumber == 8'($past(connectionFrameNumber) + 1)) else $error("counter step");
   a_cfn_hold: assert property (!linkActive && !cfnLoadValid |=> $stable(connectionFrameNumber))
      else $error("counter moved");
   a_cfn_load: assert property (cfnLoadValid |=> connectionFrameNumber == $past(cfnLoad))
      else $error("counter load");
   a_prep_first: assert property (cfgReq.request && !busy |=> prepareCmd && busy)
      else $error("prepare missing");
   a_change_next: assert property (s_prep |=> changeSignal && !prepareCmd)
      else $error("change signal");
   a_apply_frame: assert property (applyConfig |-> connectionFrameNumber == changeFrame && !busy)
      else $error("apply frame");
endmodule
bind rlfs_offset_sync rlfs_offset_sync_chk u_chk (
   .clk_sys               (clk_sys),
   .resetn                (resetn),
   .offsetReq             (offsetReq),
   .offsetRsp             (offsetRsp),
   .frameTick             (frameTick),
   .linkActive            (linkActive),
   .cfnLoad               (cfnLoad),
   .cfnLoadValid          (cfnLoadValid),
   .connectionFrameNumber (connectionFrameNumber),
   .cfgReq                (cfgReq),
   .prepareCmd            (prepareCmd),
   .prepareDone           (prepareDone),
   .changeSignal          (changeSignal),
   .changeFrame           (changeFrame),
   .applyConfig           (applyConfig),
   .busy                  (busy)
);

//--- bench/rlfs_station_model.sv
// Base station model: confirms preparation and paces radio frames
`timescale 1ns/1ps
module rlfs_station_model #(parameter int DELAY = 5, parameter int TICK = 4) (
   input  wire logic clk_sys,
   input  wire logic resetn,
   input  wire logic prepareCmd,
   output logic      prepareDone,
   output logic      frameTick
);
   int pd, fc;
   always_ff @(posedge clk_sys) begin
      if (!resetn || !prepareCmd) pd <= 0;
      else if (pd < DELAY) pd <= pd + 1;
   end
   always_ff @(posedge clk_sys) fc <= (!resetn || fc == TICK - 1) ? 0 : fc + 1;
   assign frameTick = resetn && fc == TICK - 1;
   // Confirms only after its own preparation time
   assign prepareDone = prepareCmd && pd == DELAY;
endmodule

//--- bench/rlfs_offset_sync_bench.sv
// Self-checking bench for the radio link frame offset block
`timescale 1ns/1ps
module rlfs_offset_sync_bench;
   import rlfs_pkg::*;
   logic             clk_sys = 0, resetn = 0, linkActive = 0, cfnLoadValid = 0;
   logic             frameTick, prepareCmd, prepareDone, changeSignal, applyConfig, busy;
   logic [7:0]       cfnLoad = 8'h00, connectionFrameNumber, changeFrame;
   rlfs_offset_req_t offsetReq = '0;
   rlfs_offset_rsp_t offsetRsp;
   rlfs_cfg_req_t    cfgReq = '0;
   int               fails = 0, n_tests = 0, cyc = 0;
   rlfs_offset_sync DUT (
      .clk_sys               (clk_sys),
      .resetn                (resetn),
      .offsetReq             (offsetReq),
      .offsetRsp             (offsetRsp),
      .frameTick             (frameTick),
      .linkActive            (linkActive),
      .cfnLoad               (cfnLoad),
      .cfnLoadValid          (cfnLoadValid),
      .connectionFrameNumber (connectionFrameNumber),
      .cfgReq                (cfgReq),
      .prepareCmd            (prepareCmd),
      .prepareDone           (prepareDone),
      .changeSignal          (changeSignal),
      .changeFrame           (changeFrame),
      .applyConfig           (applyConfig),
      .busy                  (busy)
   );
   rlfs_station_model #(.DELAY(5), .TICK(4)) STN (
      .clk_sys     (clk_sys),
      .resetn      (resetn),
      .prepareCmd  (prepareCmd),
      .prepareDone (prepareDone),
      .frameTick   (frameTick)
   );
   initial forever #4 clk_sys = ~clk_sys;
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         fails++;
         give_verdict();
      end
   end
   task automatic chk(string n, logic [23:0] e, logic [23:0] s);
      n_tests++;
      if (s !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic off_case(logic t, rlfs_case_t c, logic [9:0] d, logic [7:0] o, logic [15:0] m,
                           logic [7:0] ef, logic [15:0] ec, logic [7:0] rf, logic [15:0] rc);
      @(posedge clk_sys);
      offsetReq <= '{1'b1, t, c, d, o, m};
      @(posedge clk_sys);
      #1;
      chk("frame", ef, offsetRsp.linkFrameOffset);
      chk("chip", ec, offsetRsp.linkChipOffset);
      chk("round", {rf, rc}, {offsetRsp.roundedFrameOffset, offsetRsp.roundedChipOffset});
   endtask
   task automatic cfn_run();
      logic [7:0] seed;
      seed = 8'(((3 * FRAME_CHIPS - 100 * DEFAULT_DPCH_OFFSET_UNIT) / FRAME_CHIPS) % CFN_MOD);
      @(posedge clk_sys);
      cfnLoad <= seed;
      cfnLoadValid <= 1;
      @(posedge clk_sys);
      cfnLoad <= 8'(511 % CFN_MOD);
      #1 chk("cfn seed", seed, connectionFrameNumber);
      @(posedge clk_sys);
      cfnLoadValid <= 0;
      linkActive <= 1;
      #1 chk("cfn time", 8'hff, connectionFrameNumber);
      do @(negedge clk_sys); while (frameTick !== 1'b1);
      @(posedge clk_sys);
      linkActive <= 0;
      #1 chk("cfn wrap", 8'h00, connectionFrameNumber);
      repeat (8) @(posedge clk_sys);
      #1 chk("cfn hold", 8'h00, connectionFrameNumber);
   endtask
   task automatic cfg_run();
      int k;
      @(posedge clk_sys);
      linkActive <= 1;
      cfgReq <= '{1'b1, 8'h10};
      @(posedge clk_sys);
      cfgReq.request <= 0;
      #1 chk("prepare", 2'b10, {prepareCmd, changeSignal});
      for (k = 0; k < 300 && changeSignal !== 1'b1; k++) @(posedge clk_sys) #1;
      chk("change frame", 8'h10, changeFrame);
      for (k = 0; k < 300 && applyConfig !== 1'b1; k++) @(posedge clk_sys) #1;
      chk("apply", {1'b1, 1'b0, 8'h10}, {applyConfig, busy, connectionFrameNumber});
   endtask
   initial begin
      repeat (12) @(posedge clk_sys);
      resetn <= 1;
      #1 chk("reset", 12'h000, {prepareCmd, changeSignal, applyConfig, busy, connectionFrameNumber});
      off_case(0, CASE_COMMON, 10'h064, 8'h02, 16'h012c, 8'h00, 16'h0000, 8'h00, 16'h0000);
      off_case(0, CASE_FIRST_ONE, 10'h064, 8'h00, 16'h0000, 8'h01, 16'h3200, 8'h01, 16'h3200);
      off_case(1, CASE_FIRST_ONE, 10'h064, 8'h00, 16'h0000, 8'h00, 16'h0000, 8'h00, 16'h0000);
      off_case(0, CASE_FIRST_MANY, 10'h064, 8'h02, 16'h012c, 8'h03, 16'h332c, 8'h03, 16'h3300);
      off_case(0, CASE_ADD_OR_MOVE, 10'h064, 8'((12'h10b - 8'h06) % CFN_MOD), 16'h95ff,
               8'h05, 16'h95ff, 8'h06, 16'h0000);
      off_case(1, CASE_ADD_OR_MOVE, 10'h064, 8'((12'h003 - 8'hfc) % CFN_MOD), 16'h012c,
               8'h07, 16'h0000, 8'h07, 16'h0000);
      off_case(0, CASE_FROM_OTHER_RAN, 10'h001, 8'h00, 16'h0000, 8'h00, 16'h0200, 8'h00, 16'h0200);
      off_case(1, CASE_FROM_OTHER_RAN, 10'h001, 8'h03, 16'h0000, 8'h00, 16'h0000, 8'h00, 16'h0000);
      @(posedge clk_sys);
      offsetReq.valid <= 0;
      cfn_run();
      cfg_run();
      give_verdict();
   end
endmodule
